// >>> src/dsle_pkg.sv
package dsle_pkg;

  // Clock and pattern timebase
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int TICK_MS = 50;
  localparam int TICK_CYCLES_DEF = TICK_MS * CLK_FREQ_KHZ;

  // Flash timing in milliseconds
  localparam int FLICK_MS = 50;
  localparam int TRIP_ON_MS = 100;
  localparam int TRIP_GAP_MS = 500;
  localparam int FB_ON_MS = 200;
  localparam int FB_GAP_MS = 1000;

  // Phase lengths in ticks, gaps in phases
  localparam logic [7:0] FLICK_T = 8'(FLICK_MS / TICK_MS);
  localparam logic [7:0] TRIP_ON_T = 8'(TRIP_ON_MS / TICK_MS);
  localparam logic [7:0] FB_ON_T = 8'(FB_ON_MS / TICK_MS);
  localparam logic [7:0] TRIP_GAP_PH = 8'(TRIP_GAP_MS / TRIP_ON_MS);
  localparam logic [7:0] FB_GAP_PH = 8'(FB_GAP_MS / FB_ON_MS);

  // Trip codes
  localparam int NUM_TRIPS = 10;
  localparam logic [3:0] TRIP_BUS_OV = 4'h1;
  localparam logic [3:0] TRIP_PWR_MOD = 4'h2;
  localparam logic [3:0] TRIP_OVERCUR = 4'h3;
  localparam logic [3:0] TRIP_OVERSPD = 4'h4;
  localparam logic [3:0] TRIP_FEEDBACK = 4'h5;
  localparam logic [3:0] TRIP_MOT_OVL = 4'h6;
  localparam logic [3:0] TRIP_OVERTEMP = 4'h7;
  localparam logic [3:0] TRIP_DRV_OVL = 4'h8;
  localparam logic [3:0] TRIP_FOLLOW = 4'h9;
  localparam logic [3:0] TRIP_ERR_IN = 4'ha;

  // CAN bus-off threshold
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h0ff;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CAN_OFS = 8'h04;
  localparam logic [7:0] ETH_OFS = 8'h08;
  localparam logic [7:0] TRIP_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FWDL_BIT = 1;
  localparam int CTRL_FWBAD_BIT = 2;
  localparam int CTRL_START_BIT = 3;
  localparam int CAN_ERRK_LSB = 3;
  localparam int CAN_ABD_BIT = 5;
  localparam int ETH_ERR_BIT = 3;
  localparam int TRIP_SHORT_BIT = 10;
  localparam int STAT_UV_BIT = 4;
  localparam int STAT_BOFF_BIT = 5;
  localparam int STAT_LED_LSB = 6;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [5:0] CAN_RST = 6'h00;
  localparam logic [3:0] ETH_RST = 4'h0;

  typedef enum logic [2:0] {
    CAN_INIT, CAN_STOPPED, CAN_PREOP, CAN_OPER, CAN_DOWNLOAD
  } dsle_can_state_t;

  typedef enum logic [2:0] {
    ETH_NOT_ACTIVE, ETH_PREOP1, ETH_PREOP2, ETH_READY, ETH_STOPPED, ETH_BASIC, ETH_OPER
  } dsle_eth_state_t;

  typedef enum logic [2:0] {
    K_OFF, K_ON, K_BLINK, K_BLINKN, K_FLICK, K_FLICKN, K_FLASH
  } dsle_kind_t;

  // One LED pattern selection
  typedef struct packed {
    dsle_kind_t kind;
    logic [3:0] cnt;
    logic slow;
  } dsle_sel_t;

  localparam int NUM_LEDS = 6;
  localparam int LED_STAT_G = 0;
  localparam int LED_STAT_R = 1;
  localparam int LED_CAN_RUN = 2;
  localparam int LED_CAN_ERR = 3;
  localparam int LED_ETH_STAT = 4;
  localparam int LED_ETH_ERR = 5;

endpackage

// >>> src/dsle_led_encoder.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module dsle_led_encoder
  import dsle_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_TRIPS-1:0] trip_event,
  input wire logic phase_short_event,
  input wire logic bus_undervoltage_level,
  input wire logic mains_off,
  input wire logic [8:0] can_tx_err_cnt,
  input wire logic [8:0] can_rx_err_cnt,
  output logic stat_green,
  output logic stat_red,
  output logic can_run_led,
  output logic can_err_led,
  output logic eth_stat_led,
  output logic eth_err_led
);

  // Refuse a timebase that can never tick
  if (TICK_CYCLES < 1)
  begin : gen_tick_check
    $error("TICK_CYCLES must be at least one");
  end

  logic [3:0] ctrl_reg, ctrl_next;
  logic [5:0] can_reg, can_next;
  logic [3:0] eth_reg, eth_next;
  logic [NUM_TRIPS-1:0] trip_reg, trip_next;
  logic short_reg, short_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [2:0] uv_sync_reg, uv_sync_next, mo_sync_reg, mo_sync_next;
  logic uv_reg, uv_next, mo_reg, mo_next;
  logic [31:0] tick_reg, tick_next;
  logic tick;
  logic [NUM_LEDS-1:0] led_vec;
  dsle_sel_t sel [NUM_LEDS];
  logic [3:0] code;
  logic wr_en, map_hit, drv_en, uv_flag, bus_off, started, autobaud;
  dsle_can_state_t can_st;
  dsle_eth_state_t eth_st;

  // APB decode
  assign map_hit = (paddr == CTRL_OFS) || (paddr == CAN_OFS) || (paddr == ETH_OFS)
                   || (paddr == TRIP_OFS) || (paddr == STAT_OFS);
  assign wr_en = psel && penable && pwrite && ce && map_hit;
  assign pready = ce;
  assign pslverr = psel && penable && !map_hit;
  assign prdata = prdata_reg;

  assign drv_en = ctrl_reg[CTRL_EN_BIT];
  assign started = ctrl_reg[CTRL_START_BIT];
  assign autobaud = can_reg[CAN_ABD_BIT];
  assign can_st = dsle_can_state_t'(can_reg[2:0]);
  assign eth_st = dsle_eth_state_t'(eth_reg[2:0]);
  assign uv_flag = uv_reg && drv_en;
  assign bus_off = (can_tx_err_cnt > BUS_OFF_LIMIT) || (can_rx_err_cnt > BUS_OFF_LIMIT);

  // Lowest latched code, short counts as power module
  always_comb
  begin
    logic [NUM_TRIPS-1:0] eff;
    eff = trip_reg;
    eff[TRIP_PWR_MOD - 4'h1] = eff[TRIP_PWR_MOD - 4'h1] | short_reg;
    code = 4'h0;
    for (int i = NUM_TRIPS - 1; i >= 0; i--)
    begin
      if (eff[i])
        code = 4'(i + 1);
    end
  end

  // Register, sync and timebase next values
  always_comb
  begin
    ctrl_next = ctrl_reg;
    can_next = can_reg;
    eth_next = eth_reg;
    trip_next = trip_reg;
    short_next = short_reg;
    prdata_next = prdata_reg;
    uv_sync_next = {uv_sync_reg[1:0], bus_undervoltage_level};
    mo_sync_next = {mo_sync_reg[1:0], mains_off};
    uv_next = (uv_sync_reg[2] == uv_sync_reg[1]) ? uv_sync_reg[2] : uv_reg;
    mo_next = (mo_sync_reg[2] == mo_sync_reg[1]) ? mo_sync_reg[2] : mo_reg;
    tick_next = (tick_reg == TICK_CYCLES - 1) ? 32'h0 : tick_reg + 32'h1;
    if (psel && !penable)
    begin
      unique case (paddr)
        CTRL_OFS: prdata_next = {28'h0, ctrl_reg};
        CAN_OFS: prdata_next = {26'h0, can_reg};
        ETH_OFS: prdata_next = {28'h0, eth_reg};
        TRIP_OFS: prdata_next = {21'h0, short_reg, trip_reg};
        STAT_OFS: prdata_next = {20'h0, led_vec, bus_off, uv_flag, code};
        default: prdata_next = 32'h0;
      endcase
    end
    if (wr_en)
    begin
      unique case (paddr)
        CTRL_OFS: ctrl_next = pwdata[3:0];
        CAN_OFS: can_next = pwdata[5:0];
        ETH_OFS: eth_next = pwdata[3:0];
        TRIP_OFS: trip_next = trip_reg & ~pwdata[NUM_TRIPS-1:0];
        default: ;
      endcase
    end
    // Set wins over clear
    trip_next = trip_next | trip_event;
    if (mo_reg)
      short_next = 1'b0;
    if (phase_short_event)
      short_next = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RST;
      can_reg <= CAN_RST;
      eth_reg <= ETH_RST;
      trip_reg <= '0;
      short_reg <= 1'b0;
      prdata_reg <= 32'h0;
      uv_sync_reg <= 3'h0;
      mo_sync_reg <= 3'h0;
      uv_reg <= 1'b0;
      mo_reg <= 1'b0;
      tick_reg <= 32'h0;
    end
    else if (ce)
    begin
      ctrl_reg <= ctrl_next;
      can_reg <= can_next;
      eth_reg <= eth_next;
      trip_reg <= trip_next;
      short_reg <= short_next;
      prdata_reg <= prdata_next;
      uv_sync_reg <= uv_sync_next;
      mo_sync_reg <= mo_sync_next;
      uv_reg <= uv_next;
      mo_reg <= mo_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = (tick_reg == TICK_CYCLES - 1);

  // Pattern selection for every LED
  always_comb
  begin
    for (int i = 0; i < NUM_LEDS; i++)
      sel[i] = '{kind: K_OFF, cnt: 4'h0, slow: 1'b0};
    // Drive status LED
    if (ctrl_reg[CTRL_FWDL_BIT])
      sel[LED_STAT_G].kind = K_FLICK;
    else if (code != 4'h0)
      sel[LED_STAT_R] = '{kind: K_FLASH, cnt: code, slow: 1'b0};
    else if (uv_flag)
    begin
      sel[LED_STAT_G].kind = K_BLINK;
      sel[LED_STAT_R].kind = K_BLINKN;
    end
    else if (drv_en)
      sel[LED_STAT_G].kind = K_ON;
    else
      sel[LED_STAT_R].kind = K_ON;
    // CAN LEDs
    if (started)
    begin
      if (autobaud)
      begin
        sel[LED_CAN_RUN].kind = K_FLICK;
        sel[LED_CAN_ERR].kind = K_FLICKN;
      end
      else
      begin
        unique case (can_st)
          CAN_STOPPED: sel[LED_CAN_RUN] = '{kind: K_FLASH, cnt: 4'h1, slow: 1'b1};
          CAN_DOWNLOAD: sel[LED_CAN_RUN] = '{kind: K_FLASH, cnt: 4'h3, slow: 1'b1};
          CAN_PREOP: sel[LED_CAN_RUN].kind = K_BLINK;
          CAN_OPER: sel[LED_CAN_RUN].kind = K_ON;
          default: sel[LED_CAN_RUN].kind = K_OFF;
        endcase
        if (bus_off)
          sel[LED_CAN_ERR].kind = K_ON;
        else if (can_reg[CAN_ERRK_LSB+1:CAN_ERRK_LSB] != 2'h0)
          sel[LED_CAN_ERR] = '{kind: K_FLASH,
                               cnt: {2'h0, can_reg[CAN_ERRK_LSB+1:CAN_ERRK_LSB]},
                               slow: 1'b1};
      end
    end
    // Ethernet LEDs
    if (ctrl_reg[CTRL_FWBAD_BIT])
    begin
      sel[LED_ETH_STAT].kind = K_BLINK;
      sel[LED_ETH_ERR].kind = K_BLINK;
    end
    else if (started)
    begin
      unique case (eth_st)
        ETH_PREOP1: sel[LED_ETH_STAT] = '{kind: K_FLASH, cnt: 4'h1, slow: 1'b1};
        ETH_PREOP2: sel[LED_ETH_STAT] = '{kind: K_FLASH, cnt: 4'h2, slow: 1'b1};
        ETH_READY: sel[LED_ETH_STAT] = '{kind: K_FLASH, cnt: 4'h3, slow: 1'b1};
        ETH_STOPPED: sel[LED_ETH_STAT].kind = K_BLINK;
        ETH_BASIC: sel[LED_ETH_STAT].kind = K_FLICK;
        ETH_OPER: sel[LED_ETH_STAT].kind = K_ON;
        default: sel[LED_ETH_STAT].kind = K_OFF;
      endcase
      if (eth_reg[ETH_ERR_BIT])
        sel[LED_ETH_ERR].kind = K_ON;
    end
  end

  // One pattern generator per LED
  for (genvar g = 0; g < NUM_LEDS; g++)
  begin : gen_led
    dsle_sel_t held_reg, held_next;
    logic [7:0] sub_reg, sub_next, seg_reg, seg_next, ph_len, last_seg;
    logic led_reg, led_next;

    always_comb
    begin
      unique case (sel[g].kind)
        K_FLICK, K_FLICKN: ph_len = FLICK_T;
        K_FLASH: ph_len = sel[g].slow ? FB_ON_T : TRIP_ON_T;
        default: ph_len = FB_ON_T;
      endcase
      if (sel[g].kind == K_FLASH)
        last_seg = {3'h0, sel[g].cnt, 1'b0}
                   + (sel[g].slow ? FB_GAP_PH : TRIP_GAP_PH) - 8'h1;
      else
        last_seg = 8'h1;
      held_next = held_reg;
      sub_next = sub_reg;
      seg_next = seg_reg;
      if (sel[g] != held_reg)
      begin
        held_next = sel[g];
        sub_next = 8'h0;
        seg_next = 8'h0;
      end
      else if (tick)
      begin
        if (sub_reg >= ph_len - 8'h1)
        begin
          sub_next = 8'h0;
          seg_next = (seg_reg >= last_seg) ? 8'h0 : seg_reg + 8'h1;
        end
        else
          sub_next = sub_reg + 8'h1;
      end
      unique case (sel[g].kind)
        K_ON: led_next = 1'b1;
        K_BLINK, K_FLICK: led_next = !seg_next[0];
        K_BLINKN, K_FLICKN: led_next = seg_next[0];
        K_FLASH: led_next = !seg_next[0] && (seg_next < {3'h0, sel[g].cnt, 1'b0});
        default: led_next = 1'b0;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        held_reg <= '{kind: K_OFF, cnt: 4'h0, slow: 1'b0};
        sub_reg <= 8'h0;
        seg_reg <= 8'h0;
        led_reg <= 1'b0;
      end
      else if (ce)
      begin
        held_reg <= held_next;
        sub_reg <= sub_next;
        seg_reg <= seg_next;
        led_reg <= led_next;
      end
    end

    assign led_vec[g] = led_reg;

    a_restart_seq: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && sel[g] != held_reg) |=> (seg_reg == 8'h0 && sub_reg == 8'h0))
      else $error("pattern did not restart on selection change");
  end

  assign stat_green = led_vec[LED_STAT_G];
  assign stat_red = led_vec[LED_STAT_R];
  assign can_run_led = led_vec[LED_CAN_RUN];
  assign can_err_led = led_vec[LED_CAN_ERR];
  assign eth_stat_led = led_vec[LED_ETH_STAT];
  assign eth_err_led = led_vec[LED_ETH_ERR];

  // Checks
  a_run_green: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && drv_en && !uv_flag && code == 4'h0 && !ctrl_reg[CTRL_FWDL_BIT]
     && $stable(ctrl_reg)) |=> (stat_green && !stat_red))
    else $error("enabled drive not steady green");
  a_idle_red: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !drv_en && code == 4'h0 && !ctrl_reg[CTRL_FWDL_BIT]
     && $stable(ctrl_reg)) |=> (stat_red && !stat_green))
    else $error("disabled drive not steady red");
  a_trip_lowest: assert property (@(posedge pclk) disable iff (!presetn)
    (trip_reg[0] || trip_reg[TRIP_OVERCUR - 4'h1]) |-> (code <= TRIP_OVERCUR))
    else $error("shown code not the lowest latched");
  a_trip_gone_green: assert property (@(posedge pclk) disable iff (!presetn)
    (code != 4'h0 && !ctrl_reg[CTRL_FWDL_BIT] && ce) |=> !stat_green)
    else $error("green lit while trip shown");
  a_uv_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && uv_reg && !drv_en && code == 4'h0 && !ctrl_reg[CTRL_FWDL_BIT]
     && $stable(ctrl_reg)) |=> (stat_red && !stat_green))
    else $error("undervoltage raised while disabled");
  a_busoff_lit: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && started && !autobaud && bus_off) ##1 (ce && started && !autobaud && bus_off)
    |=> can_err_led)
    else $error("bus-off did not light error LED");
  a_busoff_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (can_tx_err_cnt <= BUS_OFF_LIMIT && can_rx_err_cnt <= BUS_OFF_LIMIT) |-> !bus_off)
    else $error("bus-off at or below limit");
  a_can_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !started) ##1 (ce && !started) |=> (!can_run_led && !can_err_led))
    else $error("CAN LEDs lit before startup");
  a_eth_err: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && started && eth_reg[ETH_ERR_BIT] && !ctrl_reg[CTRL_FWBAD_BIT]) [*2]
    |=> eth_err_led)
    else $error("Ethernet error LED not lit");
  a_short_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (short_reg && !mo_reg) |=> short_reg)
    else $error("phase short trip released with mains present");

  c_trip_shown: cover property (@(posedge pclk) disable iff (!presetn)
    code == TRIP_OVERCUR ##1 stat_red);
  c_uv_alt: cover property (@(posedge pclk) disable iff (!presetn)
    uv_flag && stat_green ##[1:100] uv_flag && stat_red);
  c_autobaud: cover property (@(posedge pclk) disable iff (!presetn)
    autobaud && started && can_run_led && !can_err_led);
  c_short_clear: cover property (@(posedge pclk) disable iff (!presetn)
    short_reg ##1 !short_reg);

endmodule

// >>> verification/dsle_led_observer.sv
`timescale 1ns/1ns
module dsle_led_observer #(
  parameter int GAP = 24
)(
  input wire logic pclk,
  input wire logic led,
  input wire logic clr,
  output logic [7:0] falls,
  output logic [7:0] burst,
  output logic [7:0] on_len,
  output logic [7:0] gap_len
);
  logic led_d = 1'b0;
  logic [7:0] run = 8'h00;
  logic [7:0] cnt = 8'h00;

  // Run lengths and pulses per burst, as an operator counts them
  always @(posedge pclk)
  begin
    led_d <= led;
    run <= (led != led_d) ? 8'h01 : run + 8'(run != 8'hff);
    if (clr)
    begin
      falls <= 8'h00;
      cnt <= 8'h00;
      burst <= 8'h00;
    end
    else if (led_d && !led)
    begin
      falls <= falls + 8'h01;
      cnt <= cnt + 8'h01;
      on_len <= run;
    end
    else if (led && !led_d && run > GAP)
    begin
      burst <= cnt;
      gap_len <= run;
      cnt <= 8'h00;
    end
  end
endmodule

// >>> verification/dsle_led_encoder_tb.sv
`timescale 1ns/1ns
module dsle_led_encoder_tb
  import dsle_pkg::*;
;
  localparam int TICK = 4;
  localparam logic [7:0] TRIP_C = 8'(TRIP_ON_T * TICK);
  localparam logic [7:0] FB_C = 8'(FB_ON_T * TICK);
  localparam logic [7:0] FLK_C = 8'(FLICK_T * TICK);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] can;
    logic [7:0] eth;
    logic [47:0] exp;
  } dsle_row_t;
  // LED codes per byte, top byte eth_err: 00 off, 01 on, 0b blink, 0f flicker, 1n n flashes
  localparam dsle_row_t ROWS [11] = '{
    '{8'h08, 8'h00, 8'h00, 48'h000000000100}, '{8'h09, 8'h03, 8'h06, 48'h000100010001},
    '{8'h0a, 8'h01, 8'h01, 48'h00110011000f}, '{8'h08, 8'h02, 8'h02, 48'h0012000b0100},
    '{8'h08, 8'h04, 8'h03, 48'h001300130100}, '{8'h08, 8'h0b, 8'h04, 48'h000b11010100},
    '{8'h08, 8'h13, 8'h05, 48'h000f12010100}, '{8'h08, 8'h1b, 8'h0e, 48'h010113010100},
    '{8'h00, 8'h1b, 8'h06, 48'h000000000100}, '{8'h04, 8'h00, 8'h00, 48'h0b0b00000100},
    '{8'h08, 8'h23, 8'h00, 48'h00000f0f0100}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_TRIPS-1:0] trip_event = '0;
  logic phase_short_event = 1'b0;
  logic bus_undervoltage_level = 1'b0;
  logic mains_off = 1'b0;
  logic [8:0] tx_cnt = 9'h000;
  logic [8:0] rx_cnt = 9'h000;
  logic [5:0] leds;
  logic clr = 1'b0;
  logic [7:0] o_falls [6];
  logic [7:0] o_burst [6];
  logic [7:0] o_on [6];
  logic [7:0] o_gap [6];
  logic [31:0] d;
  logic e;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  dsle_led_encoder #(.TICK_CYCLES(TICK)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trip_event(trip_event),
    .phase_short_event(phase_short_event), .bus_undervoltage_level(bus_undervoltage_level),
    .mains_off(mains_off), .can_tx_err_cnt(tx_cnt), .can_rx_err_cnt(rx_cnt),
    .stat_green(leds[0]), .stat_red(leds[1]), .can_run_led(leds[2]),
    .can_err_led(leds[3]), .eth_stat_led(leds[4]), .eth_err_led(leds[5]));

  // One operator per LED; fieldbus gaps are longer than trip gaps
  for (genvar g = 0; g < 6; g++)
  begin : obs
    dsle_led_observer #(.GAP(g < 2 ? 24 : 48)) u_obs (.pclk(pclk), .led(leds[g]),
      .clr(clr), .falls(o_falls[g]), .burst(o_burst[g]), .on_len(o_on[g]),
      .gap_len(o_gap[g]));
  end

  // Clock and hang guard
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    begin
      if (num_errors == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    begin
      n_compared++;
      if (g !== x)
      begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", n, x, g);
      end
    end
  endtask

  // Pattern seen on one LED, reduced to a code
  function automatic logic [7:0] led_code(input int j);
    logic [7:0] fl;
    begin
      fl = (j < 2) ? TRIP_C : FB_C;
      if (o_falls[j] === 8'h00)
        return {7'h00, leds[j]};
      if (o_burst[j] !== 8'h00)
        return (o_on[j] === fl) ? 8'h10 + o_burst[j] : 8'hee;
      if (o_on[j] === FB_C)
        return 8'h0b;
      return (o_on[j] === FLK_C) ? 8'h0f : 8'hee;
    end
  endfunction

  task automatic chk_led(input int j, input logic [7:0] x);
    begin
      chk($sformatf("led %0d", j), {24'h0, x}, {24'h0, led_code(j)});
    end
  endtask

  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Restart observers once the new selection is shown, then watch
  task automatic settle();
    begin
      repeat (3) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (400) @(posedge pclk);
      @(negedge pclk);
    end
  endtask

  task automatic pulse_trip(input logic [NUM_TRIPS-1:0] v, input logic s);
    begin
      @(posedge pclk);
      trip_event <= v;
      phase_short_event <= s;
      @(posedge pclk);
      trip_event <= '0;
      phase_short_event <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    chk("leds in reset", 32'h0, {26'h0, leds});
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk("reset value", 32'h0, d);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    // Ordinary display states from the table
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b1, CTRL_OFS, {24'h0, ROWS[i].ctrl});
      apb(1'b1, CAN_OFS, {24'h0, ROWS[i].can});
      apb(1'b1, ETH_OFS, {24'h0, ROWS[i].eth});
      settle();
      for (int j = 0; j < 6; j++)
        chk_led(j, ROWS[i].exp[j*8 +: 8]);
    end
    // Every trip code reaches the status register code field
    apb(1'b1, CAN_OFS, 32'h3);
    for (int i = 0; i < NUM_TRIPS; i++)
    begin
      pulse_trip(NUM_TRIPS'(1 << i), 1'b0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("shown code", 32'(i + 1), {28'h0, d[3:0]});
      apb(1'b1, TRIP_OFS, 32'h3ff);
    end
    // Two trips together, then a lower one arrives mid-sequence
    pulse_trip(NUM_TRIPS'(10'h014), 1'b0);
    settle();
    chk_led(1, 8'h13);
    chk("trip gap", 32'(TRIP_C + TRIP_GAP_PH * TRIP_C), {24'h0, o_gap[1]});
    pulse_trip(NUM_TRIPS'(10'h001), 1'b0);
    settle();
    chk_led(1, 8'h11);
    apb(1'b1, TRIP_OFS, 32'h3ff);
    settle();
    chk_led(1, 8'h01);
    // Undervoltage alone, then with a trip
    apb(1'b1, CTRL_OFS, 32'h9);
    bus_undervoltage_level <= 1'b1;
    settle();
    chk_led(0, 8'h0b);
    chk_led(1, 8'h0b);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("alternate", 32'h1, {31'h0, d[6] ^ d[7]});
    chk("uv flag on", 32'h1, {31'h0, d[STAT_UV_BIT]});
    pulse_trip(NUM_TRIPS'(10'h080), 1'b0);
    settle();
    chk_led(1, 8'h18);
    apb(1'b1, TRIP_OFS, 32'h3ff);
    apb(1'b1, CTRL_OFS, 32'h8);
    apb(1'b0, STAT_OFS, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("uv flag off", 32'h0, {31'h0, d[STAT_UV_BIT]});
    bus_undervoltage_level <= 1'b0;
    // Phase short survives a clear until mains are removed
    pulse_trip('0, 1'b1);
    apb(1'b1, TRIP_OFS, 32'h3ff);
    apb(1'b0, TRIP_OFS, 32'h0);
    chk("short held", 32'h400, d);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("short code", 32'h2, {28'h0, d[3:0]});
    mains_off <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, TRIP_OFS, 32'h0);
    chk("short cleared", 32'h0, d);
    mains_off <= 1'b0;
    // Bus-off threshold on either count
    for (int k = 0; k < 3; k++)
    begin
      tx_cnt <= (k == 0) ? 9'h0ff : ((k == 1) ? 9'h100 : 9'h000);
      rx_cnt <= (k == 2) ? 9'h100 : 9'h000;
      repeat (4) @(posedge pclk);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("bus off", 32'(k != 0), {31'h0, d[STAT_BOFF_BIT]});
      chk("can err lit", 32'(k != 0), {31'h0, d[STAT_LED_LSB + 3]});
    end
    // Clock enable low freezes the display and the bus
    apb(1'b1, CTRL_OFS, 32'ha);
    repeat (8) @(posedge pclk);
    ce <= 1'b0;
    @(negedge pclk);
    d = {26'h0, leds};
    repeat (12) @(negedge pclk);
    chk("leds frozen", d, {26'h0, leds});
    chk("pready low", 32'h0, {31'h0, pready});
    @(posedge pclk);
    ce <= 1'b1;
    // Reset in mid-run clears the latches and the display
    pulse_trip(NUM_TRIPS'(10'h002), 1'b1);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("leds in mid reset", 32'h0, {26'h0, leds});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TRIP_OFS, 32'h0);
    chk("trips after reset", 32'h0, d);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl after reset", 32'h0, d);
    @(negedge pclk);
    chk("red after reset", 32'h2, {26'h0, leds});
    test_done();
  end
endmodule
